/* File: src/fpg_gpio_bank.sv */
// Notes on behaviour
// - Port C has seven bidirectional pins, each with a data latch; two feed the converter.
// - Reset never loads or clears any port data latch bit.
// - Direction bit 1 drives the pin; 0 leaves it high-impedance input.
// - Reset clears every implemented direction bit, so all pins not claimed by a peripheral start as inputs.
// - Port C data read returns the latch for bits whose direction is 1.
// - Data read returns the pin level for bits whose direction is 0.
// - Writing a port C, E or F data address with byte lane 0 strobed updates the latch, whatever the direction.
// - Writing an input pin's latch neither drives the pin nor changes readback.
// - Port D has seven input-only pins, no direction register, shared with motor PWM.
// - Port D read returns pin levels, top bit zero; writes have no effect.
// - Port E has eight pins; five shared with timers, two with async serial.
// - Timer-claimed port E pins take drive from timer; direction still picks read source.
// - Port E data reads at its own address: latch for outputs, pins for inputs.
// - Port F has six pins; four shared with sync serial, two with async serial.
// - Serial-claimed port F pins ignore direction for drive; direction still picks read source.
// - Port F data reads at its own address: latch for outputs, pins for inputs.
`default_nettype none
module fpg_gpio_bank
   import fpg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Port C pins
   input wire logic [PC_W-1:0] i_port_c_pin,
   output logic [PC_W-1:0] o_port_c_pin,
   output logic [PC_W-1:0] o_port_c_oe_n,
   // Port D pins (input only)
   input wire logic [PD_W-1:0] i_port_d_pin,
   // Port E pins and timer overrides
   input wire logic [PE_W-1:0] i_port_e_pin,
   output logic [PE_W-1:0] o_port_e_pin,
   output logic [PE_W-1:0] o_port_e_oe_n,
   input wire logic [PE_W-1:0] i_port_e_periph_claim,
   input wire logic [PE_W-1:0] i_port_e_periph_drive,
   input wire logic [PE_W-1:0] i_port_e_periph_dout,
   // Port F pins and serial overrides
   input wire logic [PF_W-1:0] i_port_f_pin,
   output logic [PF_W-1:0] o_port_f_pin,
   output logic [PF_W-1:0] o_port_f_oe_n,
   input wire logic [PF_W-1:0] i_port_f_periph_claim,
   input wire logic [PF_W-1:0] i_port_f_periph_drive,
   input wire logic [PF_W-1:0] i_port_f_periph_dout,
   // Synchronised levels for shared peripherals (converter, motor PWM)
   output logic [PC_W-1:0] o_port_c_level,
   output logic [PD_W-1:0] o_port_d_level
);
   // Latches: no reset on purpose so contents survive reset
   logic [PC_W-1:0] port_c_data_latch_reg;
   logic [PE_W-1:0] port_e_data_latch_reg;
   logic [PF_W-1:0] port_f_data_latch_reg;
   logic [PC_W-1:0] port_c_direction_reg;
   logic [PE_W-1:0] port_e_direction_reg;
   logic [PF_W-1:0] port_f_direction_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic [PC_W-1:0] c_sync;
   logic [PD_W-1:0] d_sync;
   logic [PE_W-1:0] e_sync;
   logic [PF_W-1:0] f_sync;
   logic wr_en;
   logic rd_en;
   logic hit;
   fpg_pin_out_t c_out;
   fpg_pin_out_t e_out;
   fpg_pin_out_t f_out;

   // Pin inputs come from outside the clock domain
   fpg_pin_sync #(.W(PC_W + PD_W + PE_W + PF_W)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_port_c_pin, i_port_d_pin, i_port_e_pin, i_port_f_pin}),
      .o_level({c_sync, d_sync, e_sync, f_sync})
   );

   // Per-bit read mux: latch when output, pin when input
   function automatic logic [7:0] pick(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
      pick = (dir & lat) | (~dir & pin);
   endfunction : pick

   // Address match helper
   function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      at = (a == fpg_byte_addr(idx));
   endfunction : at

   // APB: every access completes in its first access cycle, no wait states
   assign o_pready = 1'b1;
   assign wr_en = i_psel && i_penable && i_pwrite && i_pstrb[0];
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign hit = at(i_paddr, PORT_C_DATA_IDX) || at(i_paddr, PORT_D_DATA_IDX) ||
                at(i_paddr, PORT_E_DATA_IDX) || at(i_paddr, PORT_F_DATA_IDX) ||
                at(i_paddr, PORT_C_DIR_IDX) || at(i_paddr, PORT_E_DIR_IDX) ||
                at(i_paddr, PORT_F_DIR_IDX);
   // Unmapped addresses answer with an error
   assign o_pslverr = i_psel && i_penable && !hit;

   // Data latch writes, direction ignored
   always_ff @(posedge i_clk) begin
      if (wr_en) begin
         if (at(i_paddr, PORT_C_DATA_IDX)) begin
            port_c_data_latch_reg <= i_pwdata[PC_W-1:0];
         end else if (at(i_paddr, PORT_E_DATA_IDX)) begin
            port_e_data_latch_reg <= i_pwdata[PE_W-1:0];
         end else if (at(i_paddr, PORT_F_DATA_IDX)) begin
            port_f_data_latch_reg <= i_pwdata[PF_W-1:0];
         end
      end
   end

   // Direction registers, cleared by reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         port_c_direction_reg <= DIR_RESET[PC_W-1:0];
         port_e_direction_reg <= DIR_RESET[PE_W-1:0];
         port_f_direction_reg <= DIR_RESET[PF_W-1:0];
      end else if (wr_en) begin
         if (at(i_paddr, PORT_C_DIR_IDX)) begin
            port_c_direction_reg <= i_pwdata[PC_W-1:0];
         end else if (at(i_paddr, PORT_E_DIR_IDX)) begin
            port_e_direction_reg <= i_pwdata[PE_W-1:0];
         end else if (at(i_paddr, PORT_F_DIR_IDX)) begin
            port_f_direction_reg <= i_pwdata[PF_W-1:0];
         end
      end
   end

   // Read data selection; port D writes fall through untouched
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (at(i_paddr, PORT_C_DATA_IDX)) begin
         // Top bit of all three operands is zero, so the unused bit reads zero
         rdata_next[7:0] = pick({1'b0, port_c_direction_reg}, {1'b0, port_c_data_latch_reg},
                                {1'b0, c_sync});
      end else if (at(i_paddr, PORT_D_DATA_IDX)) begin
         rdata_next[7:0] = {1'b0, d_sync};
      end else if (at(i_paddr, PORT_E_DATA_IDX)) begin
         rdata_next[7:0] = pick(port_e_direction_reg, port_e_data_latch_reg, e_sync);
      end else if (at(i_paddr, PORT_F_DATA_IDX)) begin
         rdata_next[7:0] = pick({2'b00, port_f_direction_reg}, {2'b00, port_f_data_latch_reg},
                                {2'b00, f_sync});
      end else if (at(i_paddr, PORT_C_DIR_IDX)) begin
         rdata_next[7:0] = {1'b0, port_c_direction_reg};
      end else if (at(i_paddr, PORT_E_DIR_IDX)) begin
         rdata_next[7:0] = port_e_direction_reg;
      end else if (at(i_paddr, PORT_F_DIR_IDX)) begin
         rdata_next[7:0] = {2'b00, port_f_direction_reg};
      end
   end

   // Read data from a flop, captured at the edge ending the setup phase; holds until next read
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         prdata_reg <= rdata_next;
      end
   end
   assign o_prdata = prdata_reg;

   // Pin drive: enable low drives; claiming peripherals override direction on port E and F pins
   always_comb begin
      c_out.dout = {1'b0, port_c_data_latch_reg};
      c_out.oe_n = {1'b1, ~port_c_direction_reg};
      e_out.dout = port_e_data_latch_reg;
      e_out.oe_n = ~port_e_direction_reg;
      f_out.dout = {2'b00, port_f_data_latch_reg};
      f_out.oe_n = {2'b11, ~port_f_direction_reg};
      for (int b = 0; b < PE_W; b++) begin
         if (i_port_e_periph_claim[b]) begin
            e_out.oe_n[b] = !i_port_e_periph_drive[b];
            e_out.dout[b] = i_port_e_periph_dout[b];
         end
      end
      for (int b = 0; b < PF_W; b++) begin
         if (i_port_f_periph_claim[b]) begin
            f_out.oe_n[b] = !i_port_f_periph_drive[b];
            f_out.dout[b] = i_port_f_periph_dout[b];
         end
      end
   end

   assign o_port_c_pin = c_out.dout[PC_W-1:0];
   assign o_port_c_oe_n = c_out.oe_n[PC_W-1:0];
   assign o_port_e_pin = e_out.dout;
   assign o_port_e_oe_n = e_out.oe_n;
   assign o_port_f_pin = f_out.dout[PF_W-1:0];
   assign o_port_f_oe_n = f_out.oe_n[PF_W-1:0];
   // Shared pins seen by converter and motor PWM
   assign o_port_c_level = c_sync;
   assign o_port_d_level = d_sync;
endmodule : fpg_gpio_bank
`default_nettype wire

/* File: src/fpg_pin_sync.sv */
`default_nettype none
module fpg_pin_sync
   import fpg_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // Three-stage chain; the first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Accept a change only once stages two and three agree, filtering one-cycle noise
   generate
      for (genvar b = 0; b < W; b++) begin : g_bit
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               o_level[b] <= 1'b0;
            end else if (s2_reg[b] == s3_reg[b]) begin
               o_level[b] <= s3_reg[b];
            end
         end
      end
   endgenerate
endmodule : fpg_pin_sync
`default_nettype wire

/* File: src/fpg_pkg.sv */
`default_nettype none
package fpg_pkg;
   // Register byte addresses. Some printed offsets are not word multiples,
   // so each printed offset is an index and the byte address is four times it.
   localparam logic [7:0] PORT_C_DATA_IDX = 8'h02;
   localparam logic [7:0] PORT_D_DATA_IDX = 8'h03;
   localparam logic [7:0] PORT_E_DATA_IDX = 8'h08;
   localparam logic [7:0] PORT_F_DATA_IDX = 8'h09;
   localparam logic [7:0] PORT_C_DIR_IDX = 8'h06;
   localparam logic [7:0] PORT_E_DIR_IDX = 8'h0c;
   localparam logic [7:0] PORT_F_DIR_IDX = 8'h0d;
   localparam int ADDR_W = 12;

   // Port widths
   localparam int PC_W = 7;
   localparam int PD_W = 7;
   localparam int PE_W = 8;
   localparam int PF_W = 6;

   // Direction reset value: all inputs
   localparam logic [7:0] DIR_RESET = 8'h00;
   // Number of synchroniser stages on pin inputs
   localparam int SYNC_STAGES = 3;

   // Pin group for one port: drive out, output enable (low = drive)
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
   } fpg_pin_out_t;

   // Register index to byte address
   function automatic logic [ADDR_W-1:0] fpg_byte_addr(input logic [7:0] idx);
      fpg_byte_addr = {2'b00, idx, 2'b00};
   endfunction : fpg_byte_addr
endpackage : fpg_pkg
`default_nettype wire

/* File: test/fpg_assertions.sv */
`default_nettype none
module fpg_assertions
   import fpg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic [PC_W-1:0] o_port_c_pin,
   input wire logic [PC_W-1:0] o_port_c_oe_n,
   input wire logic [PE_W-1:0] o_port_e_oe_n,
   input wire logic [PE_W-1:0] i_port_e_periph_claim,
   input wire logic [PE_W-1:0] i_port_e_periph_drive,
   input wire logic [PF_W-1:0] o_port_f_oe_n,
   input wire logic [PF_W-1:0] i_port_f_periph_claim,
   input wire logic [PF_W-1:0] i_port_f_periph_drive
);
   logic wr;
   logic rd;
   // Access phases; writes need the low byte lane
   assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0];
   assign rd = i_psel && i_penable && !i_pwrite;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_reset_inputs: assert property ($rose(i_rst_n) |-> o_port_c_oe_n == 7'h7f &&
      (o_port_e_oe_n | i_port_e_periph_claim) == 8'hff) else $error("pins not inputs after reset");
   a_c_dir: assert property (wr && i_paddr == 12'h018 |=> o_port_c_oe_n == ~$past(i_pwdata[6:0]))
      else $error("port c enable wrong");
   a_c_latch: assert property (wr && i_paddr == 12'h008 |=> o_port_c_pin == $past(i_pwdata[6:0]))
      else $error("port c latch wrong");
   a_e_claim: assert property ((o_port_e_oe_n & i_port_e_periph_claim) ==
      (~i_port_e_periph_drive & i_port_e_periph_claim)) else $error("port e claim drive wrong");
   a_f_claim: assert property ((o_port_f_oe_n & i_port_f_periph_claim) ==
      (~i_port_f_periph_drive & i_port_f_periph_claim)) else $error("port f claim drive wrong");
   a_f_dir: assert property (wr && i_paddr == 12'h034 |=> i_port_f_periph_claim != 6'h00 ||
      o_port_f_oe_n == ~$past(i_pwdata[5:0])) else $error("port f enable wrong");
   a_d_top: assert property (rd && i_paddr == 12'h00c |-> o_prdata[31:7] == 25'h0)
      else $error("port d top bit set");
   a_c_upper: assert property (rd && (i_paddr == 12'h008 || i_paddr == 12'h018) |-> o_prdata[31:7] == 25'h0)
      else $error("port c upper bits set");
   a_f_upper: assert property (rd && (i_paddr == 12'h024 || i_paddr == 12'h034) |-> o_prdata[31:6] == 26'h0)
      else $error("port f upper bits set");
   c_c_dir: cover property (wr && i_paddr == 12'h018);
   c_e_claim: cover property (wr && i_port_e_periph_claim != 8'h00);
   c_d_read: cover property (rd && i_paddr == 12'h00c);
endmodule : fpg_assertions
bind fpg_gpio_bank fpg_assertions u_chk (.*);
`default_nettype wire

/* File: test/fpg_pin_model.sv */
`default_nettype none
module fpg_pin_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] i_ext,
   input wire logic [W-1:0] i_dout,
   input wire logic [W-1:0] i_oe_n,
   output logic [W-1:0] o_level
);
   // Driven bits show the block's value; released bits show the outside level
   assign o_level = (i_dout & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : fpg_pin_model
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb;
   import fpg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ba
   logic i_clk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hf;
   logic [7:0] x [4] = '{default: 8'h00}, cl [3] = '{default: 8'h00}, dv [3], pd [3];
   logic [6:0] pc, oec, lvc, lc, ld;
   logic [7:0] pe, oee, lve;
   logic [5:0] pf, oef, lvf;
   logic [11:0] da [4] = '{ba(PORT_C_DATA_IDX), ba(PORT_E_DATA_IDX), ba(PORT_F_DATA_IDX), ba(PORT_D_DATA_IDX)};
   logic [11:0] ra [3] = '{ba(PORT_C_DIR_IDX), ba(PORT_E_DIR_IDX), ba(PORT_F_DIR_IDX)};
   logic [7:0] m [3] = '{8'h7f, 8'hff, 8'h3f};
   int errors = 0, total_checks = 0;
   fpg_pin_model #(.W(7)) u_pc (.i_ext(x[0][6:0]), .i_dout(pc), .i_oe_n(oec), .o_level(lvc));
   fpg_pin_model #(.W(8)) u_pe (.i_ext(x[1]), .i_dout(pe), .i_oe_n(oee), .o_level(lve));
   fpg_pin_model #(.W(6)) u_pf (.i_ext(x[2][5:0]), .i_dout(pf), .i_oe_n(oef), .o_level(lvf));
   fpg_gpio_bank dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_port_c_pin(lvc), .o_port_c_pin(pc), .o_port_c_oe_n(oec),
      .i_port_d_pin(x[3][6:0]), .i_port_e_pin(lve), .o_port_e_pin(pe), .o_port_e_oe_n(oee),
      .i_port_e_periph_claim(cl[1]), .i_port_e_periph_drive(dv[1]), .i_port_e_periph_dout(pd[1]),
      .i_port_f_pin(lvf), .o_port_f_pin(pf), .o_port_f_oe_n(oef), .i_port_f_periph_claim(cl[2][5:0]),
      .i_port_f_periph_drive(dv[2][5:0]), .i_port_f_periph_dout(pd[2][5:0]), .o_port_c_level(lc),
      .o_port_d_level(ld));
   task automatic end_of_test();
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask : chk
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
         output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge i_clk);
      pen <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
      @(posedge i_clk);
   endtask : apb
   // Read value: latch where direction is 1, else the resolved pin level
   function automatic logic [7:0] exp_rd(input logic [7:0] l, dr, xv, c, v, p);
      logic [7:0] en, pin;
      en = (c & v) | (~c & dr);
      pin = (en & ((c & p) | (~c & l))) | (~en & xv);
      return (dr & l) | (~dr & pin);
   endfunction : exp_rd
   // Free-running 10 MHz clock
   initial begin
      forever #50 i_clk = ~i_clk;
   end
   // Main sequence
   initial begin
      logic [31:0] r;
      logic e;
      logic [7:0] l [3], dr [3];
      void'($urandom(18982));
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      for (int p = 0; p < 3; p++) begin
         apb(1'b0, ra[p], 8'h00, r, e);
         chk("direction after reset", 32'h0, r);
      end
      for (int i = 0; i < 24; i++) begin
         for (int p = 0; p < 4; p++)
            x[p] <= 8'($urandom);
         for (int p = 1; p < 3; p++) begin
            cl[p] <= (i < 8) ? 8'h00 : 8'($urandom);
            dv[p] <= 8'($urandom);
            pd[p] <= 8'($urandom);
         end
         // Corner cases first: all ones, all outputs, all inputs
         for (int p = 0; p < 3; p++) begin
            l[p] = (i == 0) ? 8'hff : 8'($urandom);
            dr[p] = (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($urandom);
            apb(1'b1, da[p], l[p], r, e);
            apb(1'b1, ra[p], dr[p], r, e);
         end
         apb(1'b1, da[3], 8'($urandom), r, e);
         // Pin path settles four edges after a change
         repeat (6) @(posedge i_clk);
         for (int p = 0; p < 3; p++) begin
            apb(1'b0, da[p], 8'h00, r, e);
            chk("port data", 32'(exp_rd(l[p], dr[p], x[p], cl[p], dv[p], pd[p]) & m[p]), r);
            apb(1'b0, ra[p], 8'h00, r, e);
            chk("direction", 32'(dr[p] & m[p]), r);
         end
         apb(1'b0, da[3], 8'h00, r, e);
         chk("port d", 32'(x[3] & 8'h7f), r);
         chk("port c drive", 32'(l[0] & 8'h7f), 32'(pc));
         chk("port c enable", 32'(~dr[0] & 8'h7f), 32'(oec));
         chk("port c level", 32'(exp_rd(l[0], dr[0], x[0], 8'h00, 8'h00, 8'h00) & 8'h7f), 32'(lc));
         chk("port d level", 32'(x[3] & 8'h7f), 32'(ld));
         chk("mapped no error", 32'h0, 32'(e));
      end
      pstrb <= 4'h0;
      apb(1'b1, da[0], ~l[0], r, e);
      pstrb <= 4'hf;
      chk("masked write", 32'(l[0] & 8'h7f), 32'(pc));
      apb(1'b0, 12'h03c, 8'h00, r, e);
      chk("unmapped error", 32'h1, 32'(e));
      chk("unmapped read", 32'h0, r);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      chk("latch after reset", 32'(l[0] & 8'h7f), 32'(pc));
      chk("enables after reset", 32'h7f, 32'(oec));
      end_of_test();
   end
endmodule : tb
`default_nettype wire
